// ---- irq_block_params.svh ----
`ifndef IRQ_BLOCK_PARAMS_SVH
`define IRQ_BLOCK_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_PRIM_STATUS 16'h4010
`define IDX_STATUS_ONE 16'h4011
`define IDX_STATUS_TWO 16'h4012
`define IDX_GPIO_STATUS 16'h4015
`define IDX_PRIM_MASK 16'h4018
`define IDX_MASK_ONE 16'h4019
`define IDX_MASK_TWO 16'h401A
`define IDX_GPIO_MASK 16'h401D
`define IDX_TRIG_SEL 16'h4030

// Primary summary bit positions
`define POS_PS_SUM 15
`define POS_THERM_SUM 14
`define POS_PIN_SUM 13
`define POS_BTN_SUM 12
`define POS_TOG_SUM 11

// Secondary bit positions
`define POS_POR 2
`define POS_LOWP 1
`define POS_ACT 0
`define POS_THW 1
`define POS_BTN 12
`define POS_TOG 11

// Implemented bits and reset values
`define IMPL_PRIM 16'hF800
`define IMPL_ONE 16'h1802
`define IMPL_TWO 16'h0007
`define RST_PRIM_MASK 16'hF800
`define RST_MASK_ONE 16'h1802
`define RST_MASK_TWO 16'h0007
`define RST_GPIO_MASK 16'hFFFF
`define RST_TRIG_SEL 32'h0000_0000

// Positions in the synchronised event vector
`define IN_POR 0
`define IN_LOWP 1
`define IN_ACT 2
`define IN_THW 3
`define IN_BTN 4
`define IN_TOG 5
`define IN_GPIO 6

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- irq_types_pkg.sv ----
package irq_types_pkg;

	// Per-pin trigger selection, two bits per pin
	typedef enum logic [1:0]
	{
		trig_rising = 2'b00,
		trig_falling = 2'b01,
		trig_both = 2'b10,
		trig_level = 2'b11
	} trig_mode_t;

	typedef logic [15:0] reg_word_t;

endpackage

// ---- secondary_irq_status_mask.sv ----
// Operation
// [RQ1] Power-on reset rising edge sets status-two bit 2 until cleared.
// [RQ2] Entry to sleep or off sets status-two bit 1 on rising edge.
// [RQ3] Entry to on or wake sets status-two bit 0 on rising edge.
// [RQ4] Status bits are sticky; writing one clears, writing zero keeps.
// [RQ5] Mask bit one blocks the event from its summary; zero passes.
// [RQ6] Status bits latch and read back regardless of their mask.
// [RQ7] All secondary mask bits come out of reset as one.
// [RQ8] Thermal warning sets status-one bit 1 on both edges.
// [RQ9] Sixteen pin event bits with matching mask feed the pin summary.
// [RQ10] Each pin event follows its own trigger selection.
// [RQ11] Power button sets status-one bit 12 on both edges; mask blocks.
// [RQ12] Timeout rising edge sets status-one bit 11, mask-one bit 11.
// [RQ13] Power-state masks sit at mask-two bits 2, 1 and 0.
// [RQ14] Summary bits are read-only, set while any unmasked source set.
// [RQ15] Summaries at bits 15, 14, 13, 12, 11 of primary status.
// [RQ16] Set primary mask keeps summary off the pin; resets to one.
// [RQ17] Interrupt output low while any summary is set and unmasked.
// [RQ18] Inputs synchronised and edge detected; set beats clear.
`timescale 1ns/1ns
`include "irq_block_params.svh"

module secondary_irq_status_mask
	import irq_types_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int GPIO_N = 16
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// Write data channel
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// Write response channel
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read address channel
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// Read data channel
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Event sources, asynchronous levels
	input wire logic poweron_reset_event,
	input wire logic enter_low_power_event,
	input wire logic enter_active_event,
	input wire logic thermal_warning_event,
	input wire logic power_button_event,
	input wire logic timeout_guard_event,
	input wire logic [GPIO_N-1:0] gpio_pin,
	// Interrupt outputs
	output logic irq_n,
	output logic irq
);

	localparam int EV_N = `IN_GPIO + GPIO_N;
	localparam logic [15:0] GPIO_IMPL = 16'((32'd1 << GPIO_N) - 32'd1);

	// Refuse widths the register map cannot hold, at elaboration
	if (ADDR_W < 18 || ADDR_W > 32 || GPIO_N < 1 || GPIO_N > 16)
	begin : bad_params
		$error("secondary_irq_status_mask: bad parameters");
	end

	// Byte strobes to a per-bit enable for a 16-bit register
	function automatic reg_word_t lane_en(input logic [1:0] strb);
		lane_en = {{8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// Byte-lane merge of a write into a 16-bit register
	function automatic reg_word_t merge16(input reg_word_t old,
		input reg_word_t val, input logic [1:0] strb);
		reg_word_t en;
		en = lane_en(strb);
		merge16 = (old & ~en) | (val & en);
	endfunction

	// Pin trigger decode
	function automatic logic pin_hit(input trig_mode_t m,
		input logic rise, input logic fall, input logic lvl);
		unique case (m)
			trig_rising: pin_hit = rise;
			trig_falling: pin_hit = fall;
			trig_both: pin_hit = rise | fall;
			trig_level: pin_hit = lvl;
		endcase
	endfunction

	logic [EV_N-1:0] ev_raw;
	logic [EV_N-1:0] sync1;
	logic [EV_N-1:0] sync2;
	logic [EV_N-1:0] sync3;
	logic [EV_N-1:0] lvl;
	logic [EV_N-1:0] lvl_q;
	logic [EV_N-1:0] ev_rise;
	logic [EV_N-1:0] ev_fall;
	reg_word_t st_one;
	reg_word_t st_two;
	reg_word_t gpio_st;
	reg_word_t mask_one;
	reg_word_t mask_two;
	reg_word_t gpio_mask;
	reg_word_t prim_mask;
	reg_word_t prim;
	logic [31:0] trig_sel;
	reg_word_t set_one;
	reg_word_t set_two;
	reg_word_t set_gpio;
	reg_word_t clr_one;
	reg_word_t clr_two;
	reg_word_t clr_gpio;
	logic aw_have;
	logic w_have;
	logic [ADDR_W-3:0] wr_idx;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_go;
	logic wr_hit;
	logic [ADDR_W-3:0] rd_idx;
	logic [31:0] next_rdata;
	logic rd_hit;

	assign ev_raw = {gpio_pin, timeout_guard_event, power_button_event,
		thermal_warning_event, enter_active_event,
		enter_low_power_event, poweron_reset_event};

	// Three-stage synchroniser; first stage feeds only the second
	// [RQ18] input synchronisation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end
		else
		begin
			sync1 <= ev_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Accept a change only once stages two and three agree
	// [RQ18] edge detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lvl <= '0;
			lvl_q <= '0;
		end
		else
		begin
			for (int i = 0; i < EV_N; i++)
				if (sync2[i] == sync3[i])
					lvl[i] <= sync3[i];
			lvl_q <= lvl;
		end
	end

	assign ev_rise = lvl & ~lvl_q;
	assign ev_fall = ~lvl & lvl_q;

	// Hardware set terms per register
	always_comb
	begin
		set_two = '0;
		set_one = '0;
		set_gpio = '0;
		// [RQ1] power-on reset edge
		set_two[`POS_POR] = ev_rise[`IN_POR];
		// [RQ2] low-power entry edge
		set_two[`POS_LOWP] = ev_rise[`IN_LOWP];
		// [RQ3] active entry edge
		set_two[`POS_ACT] = ev_rise[`IN_ACT];
		// [RQ8] thermal both edges
		set_one[`POS_THW] = ev_rise[`IN_THW] | ev_fall[`IN_THW];
		// [RQ11] button both edges
		set_one[`POS_BTN] = ev_rise[`IN_BTN] | ev_fall[`IN_BTN];
		// [RQ12] timeout rising edge
		set_one[`POS_TOG] = ev_rise[`IN_TOG];
		// [RQ10] per-pin trigger select
		for (int i = 0; i < GPIO_N; i++)
			set_gpio[i] = pin_hit(trig_mode_t'(trig_sel[2*i +: 2]),
				ev_rise[`IN_GPIO+i], ev_fall[`IN_GPIO+i],
				lvl[`IN_GPIO+i]);
	end

	// Write-one-to-clear terms from the bus
	// [RQ4] clear on written ones
	always_comb
	begin
		clr_one = '0;
		clr_two = '0;
		clr_gpio = '0;
		if (wr_go)
		begin
			if (wr_idx == `IDX_STATUS_ONE)
				clr_one = wr_data[15:0] & lane_en(wr_strb[1:0]);
			if (wr_idx == `IDX_STATUS_TWO)
				clr_two = wr_data[15:0] & lane_en(wr_strb[1:0]);
			if (wr_idx == `IDX_GPIO_STATUS)
				clr_gpio = wr_data[15:0] & lane_en(wr_strb[1:0]);
		end
	end

	// Sticky status; latching ignores masks, set wins over clear
	// [RQ6] latch regardless of mask
	// [RQ18] set beats clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_one <= '0;
			st_two <= '0;
			gpio_st <= '0;
		end
		else
		begin
			st_one <= ((st_one & ~clr_one) | set_one) & `IMPL_ONE;
			st_two <= ((st_two & ~clr_two) | set_two) & `IMPL_TWO;
			gpio_st <= ((gpio_st & ~clr_gpio) | set_gpio) & GPIO_IMPL;
		end
	end

	// Mask and trigger configuration registers
	// [RQ7] masks reset to one
	// [RQ13] power-state mask layout
	// [RQ16] primary masks reset to one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mask_one <= `RST_MASK_ONE;
			mask_two <= `RST_MASK_TWO;
			gpio_mask <= `RST_GPIO_MASK & GPIO_IMPL;
			prim_mask <= `RST_PRIM_MASK;
			trig_sel <= `RST_TRIG_SEL;
		end
		else if (wr_go)
		begin
			if (wr_idx == `IDX_MASK_ONE)
				mask_one <= merge16(mask_one, wr_data[15:0],
					wr_strb[1:0]) & `IMPL_ONE;
			if (wr_idx == `IDX_MASK_TWO)
				mask_two <= merge16(mask_two, wr_data[15:0],
					wr_strb[1:0]) & `IMPL_TWO;
			if (wr_idx == `IDX_GPIO_MASK)
				gpio_mask <= merge16(gpio_mask, wr_data[15:0],
					wr_strb[1:0]) & GPIO_IMPL;
			if (wr_idx == `IDX_PRIM_MASK)
				prim_mask <= merge16(prim_mask, wr_data[15:0],
					wr_strb[1:0]) & `IMPL_PRIM;
			if (wr_idx == `IDX_TRIG_SEL)
				for (int b = 0; b < 4; b++)
					if (wr_strb[b])
						trig_sel[8*b +: 8] <= wr_data[8*b +: 8];
		end
	end

	// Primary summaries, derived and so read-only
	// [RQ5] mask gates propagation
	// [RQ9] pin group aggregation
	// [RQ14] summary follows sources
	// [RQ15] summary bit layout
	always_comb
	begin
		prim = '0;
		prim[`POS_PS_SUM] = |(st_two & ~mask_two);
		prim[`POS_THERM_SUM] = st_one[`POS_THW] & ~mask_one[`POS_THW];
		prim[`POS_PIN_SUM] = |(gpio_st & ~gpio_mask);
		prim[`POS_BTN_SUM] = st_one[`POS_BTN] & ~mask_one[`POS_BTN];
		prim[`POS_TOG_SUM] = st_one[`POS_TOG] & ~mask_one[`POS_TOG];
	end

	// Registered interrupt outputs, so no glitch reaches the pin
	// [RQ17] drive interrupt output
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_n <= 1'b1;
			irq <= 1'b0;
		end
		else
		begin
			irq_n <= ~|(prim & ~prim_mask);
			irq <= |(prim & ~prim_mask);
		end
	end

	// Write path: address and data taken in either order
	assign wr_go = aw_have & w_have;
	assign wr_hit = wr_idx == `IDX_STATUS_ONE ||
		wr_idx == `IDX_STATUS_TWO || wr_idx == `IDX_GPIO_STATUS ||
		wr_idx == `IDX_MASK_ONE || wr_idx == `IDX_MASK_TWO ||
		wr_idx == `IDX_GPIO_MASK || wr_idx == `IDX_PRIM_MASK ||
		wr_idx == `IDX_TRIG_SEL || wr_idx == `IDX_PRIM_STATUS;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			wr_idx <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready <= 1'b0;
				aw_have <= 1'b1;
				wr_idx <= awaddr[ADDR_W-1:2];
			end
			if (wvalid && wready)
			begin
				wready <= 1'b0;
				w_have <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_go)
			begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read decode; unmapped words read zero with an error
	assign rd_idx = araddr[ADDR_W-1:2];

	always_comb
	begin
		next_rdata = '0;
		rd_hit = 1'b1;
		if (rd_idx == `IDX_PRIM_STATUS)
			next_rdata[15:0] = prim;
		else if (rd_idx == `IDX_STATUS_ONE)
			next_rdata[15:0] = st_one;
		else if (rd_idx == `IDX_STATUS_TWO)
			next_rdata[15:0] = st_two;
		else if (rd_idx == `IDX_GPIO_STATUS)
			next_rdata[15:0] = gpio_st;
		else if (rd_idx == `IDX_PRIM_MASK)
			next_rdata[15:0] = prim_mask;
		else if (rd_idx == `IDX_MASK_ONE)
			next_rdata[15:0] = mask_one;
		else if (rd_idx == `IDX_MASK_TWO)
			next_rdata[15:0] = mask_two;
		else if (rd_idx == `IDX_GPIO_MASK)
			next_rdata[15:0] = gpio_mask;
		else if (rd_idx == `IDX_TRIG_SEL)
			next_rdata = trig_sel;
		else
			rd_hit = 1'b0;
	end

	// Read channel, one outstanding read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// [RQ1] power-on reset latch
	por_set_a: assert property ( // [RQ1]
		ev_rise[`IN_POR] |=> st_two[`POS_POR])
		else $error("power-on reset event not latched");
	// [RQ2] low-power latch
	lowp_set_a: assert property ( // [RQ2]
		ev_rise[`IN_LOWP] |=> st_two[`POS_LOWP])
		else $error("low-power entry not latched");
	// [RQ3] active entry latch
	act_set_a: assert property ( // [RQ3]
		ev_rise[`IN_ACT] |=> st_two[`POS_ACT])
		else $error("active entry not latched");
	// [RQ4] sticky until cleared
	sticky_hold_a: assert property ( // [RQ4]
		st_one[`POS_BTN] && !clr_one[`POS_BTN]
		|=> st_one[`POS_BTN])
		else $error("status bit dropped without clear");
	// [RQ4] clear by writing one
	w1c_clear_a: assert property ( // [RQ4]
		clr_two[`POS_ACT] && !set_two[`POS_ACT]
		|=> !st_two[`POS_ACT])
		else $error("write of one did not clear");
	// [RQ6] latch under mask
	masked_latch_a: assert property ( // [RQ6]
		mask_two[`POS_POR] && ev_rise[`IN_POR]
		|=> st_two[`POS_POR])
		else $error("masked event not recorded");
	// [RQ7] masks after reset
	mask_reset_a: assert property ( // [RQ7]
		disable iff (1'b0)
		!aresetn ##1 aresetn |-> mask_two == `RST_MASK_TWO &&
		mask_one == `RST_MASK_ONE && prim_mask == `RST_PRIM_MASK)
		else $error("mask reset value wrong");
	// [RQ8] thermal falling edge
	therm_fall_a: assert property ( // [RQ8]
		ev_fall[`IN_THW] |=> st_one[`POS_THW])
		else $error("thermal falling edge missed");
	// [RQ10] level trigger on pin three, the level pin in use
	pin_level_a: assert property ( // [RQ10]
		trig_sel[7:6] == trig_level && lvl[`IN_GPIO+3]
		|=> gpio_st[3])
		else $error("pin level trigger missed");
	// [RQ11] masked button stays off summary
	btn_mask_a: assert property ( // [RQ11]
		mask_one[`POS_BTN] |-> !prim[`POS_BTN_SUM])
		else $error("masked button reached summary");
	// [RQ12] timeout latch
	tog_set_a: assert property ( // [RQ12]
		ev_rise[`IN_TOG] |=> st_one[`POS_TOG])
		else $error("timeout not latched");
	// [RQ14] power summary tracks sources
	ps_sum_a: assert property ( // [RQ14]
		prim[`POS_PS_SUM] == |(st_two & ~mask_two))
		else $error("power summary mismatch");
	// [RQ17] pin follows summary a cycle later
	irq_pin_a: assert property ( // [RQ17]
		##1 irq_n == $past(~|(prim & ~prim_mask)))
		else $error("interrupt pin out of step");
	// [RQ18] level re-set meets a clear-write; set must win
	set_wins_a: assert property ( // [RQ18]
		clr_gpio[3] && set_gpio[3] |=> gpio_st[3])
		else $error("clear beat a coincident set");
	// Write response held until taken, dropped on the taking edge
	bresp_hold_a: assert property (
		bvalid |=> bvalid == !$past(bready))
		else $error("write response dropped early");

	por_seen_c: cover property (ev_rise[`IN_POR] ##1 st_two[`POS_POR]);
	irq_low_c: cover property (irq_n ##1 !irq_n);
	clr_pin_c: cover property (|clr_gpio ##1 gpio_st == '0);
	rd_done_c: cover property (rvalid && rready && rresp == `RESP_OKAY);

endmodule

// ---- host_irq_watch.sv ----
`timescale 1ns/1ns

module host_irq_watch
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Interrupt pin from the device
	input wire logic irq_n,
	// Handler entries seen by the host
	output logic [7:0] irq_seen
);
	logic irq_n_q;

	// active low request
	// Count new low levels only; a held low is one request
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_n_q <= 1'b1;
			irq_seen <= 8'h00;
		end
		else
		begin
			irq_n_q <= irq_n;
			if (irq_n_q && !irq_n)
				irq_seen <= irq_seen + 8'h01;
		end
	end
endmodule

// ---- secondary_irq_status_mask_tb.sv ----
`timescale 1ns/1ns
`include "irq_block_params.svh"

module secondary_irq_status_mask_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq_n, irq;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] ev;
	logic [15:0] gpio_pin;
	logic [7:0] irq_seen;
	int failures, n_checks;
	int sb [6] = '{`POS_POR, `POS_LOWP, `POS_ACT, `POS_THW, `POS_BTN, `POS_TOG};
	int pb [6] = '{15, 15, 15, 14, 12, 11};
	logic [15:0] ri [7] = '{`IDX_MASK_ONE, `IDX_MASK_TWO, `IDX_GPIO_MASK,
		`IDX_PRIM_MASK, `IDX_STATUS_ONE, `IDX_STATUS_TWO, `IDX_GPIO_STATUS};
	logic [31:0] re [7] = '{32'h0000_1802, 32'h0000_0007, 32'h0000_FFFF,
		32'h0000_F800, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

	secondary_irq_status_mask DUT
	(
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready,
		.poweron_reset_event(ev[0]),
		.enter_low_power_event(ev[1]),
		.enter_active_event(ev[2]),
		.thermal_warning_event(ev[3]),
		.power_button_event(ev[4]),
		.timeout_guard_event(ev[5]),
		.gpio_pin, .irq_n, .irq
	);

	host_irq_watch host (.aclk, .aresetn, .irq_n, .irq_seen);

	// Free running 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
		begin
			failures++;
			wrap_up();
		end
	endtask

	// Read: data and response taken at the rvalid edge
	task automatic rd(input logic [15:0] idx);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				rv = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
		begin
			failures++;
			wrap_up();
		end
	endtask

	// Main sequence
	initial
	begin
		logic [15:0] si;
		logic [31:0] m, mr;
		aresetn <= 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'b00000;
		awaddr <= 18'h0_0000;
		araddr <= 18'h0_0000;
		wdata <= 32'h0000_0000;
		wstrb <= 4'hF;
		ev <= 6'b00_0000;
		gpio_pin <= 16'h0000;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			rd(ri[i]);
			chk("reset value", rv, re[i]);
		end
		chk("pin idle", irq_n, 1'b1);
		rd(16'h4000);
		chk("unmapped read", {rv[29:0], resp}, 32'h0000_0002);
		wr(16'h4000, 32'h0000_0001);
		chk("unmapped write", resp, 2'b10);
		$display("test reset done");

		wr(`IDX_PRIM_MASK, 32'h0000_0000);
		chk("write okay", resp, 2'b00);
		for (int i = 0; i < 6; i++)
		begin
			si = (i < 3) ? `IDX_STATUS_TWO : `IDX_STATUS_ONE;
			mr = (i < 3) ? 32'h0000_0007 : 32'h0000_1802;
			m = 32'h1 << sb[i];
			@(posedge aclk);
			ev[i] <= 1'b1;
			repeat (8) @(posedge aclk);
			rd(si);
			chk("rising edge", rv, m);
			rd(`IDX_PRIM_STATUS);
			chk("summary masked", rv, 32'h0000_0000);
			chk("pin masked", irq_n, 1'b1);
			wr(si + 16'h0008, mr & ~m);
			rd(`IDX_PRIM_STATUS);
			chk("summary", rv, 32'h1 << pb[i]);
			chk("pin low", irq_n, 1'b0);
			chk("pin high", irq, 1'b1);
			wr(si + 16'h0008, mr);
			wr(si, 32'h0000_0000);
			rd(si);
			chk("zero write", rv, m);
			wr(si, m);
			rd(si);
			chk("one write", rv, 32'h0000_0000);
			@(posedge aclk);
			ev[i] <= 1'b0;
			repeat (8) @(posedge aclk);
			rd(si);
			chk("falling edge", rv, (i == 3 || i == 4) ? m : 0);
			wr(si, m);
		end
		chk("requests", irq_seen, 8'h06);
		$display("test events done");

		// Pins 0..3: rising, falling, both, level; pin 15 rising
		wr(`IDX_TRIG_SEL, 32'h0000_00E4);
		wr(`IDX_GPIO_MASK, 32'h0000_0000);
		@(posedge aclk);
		gpio_pin <= 16'h800F;
		repeat (8) @(posedge aclk);
		rd(`IDX_GPIO_STATUS);
		chk("pin rise", rv, 32'h0000_800D);
		wr(`IDX_GPIO_STATUS, 32'h0000_FFFF);
		rd(`IDX_GPIO_STATUS);
		chk("level reset", rv, 32'h0000_0008);
		wr(`IDX_PRIM_STATUS, 32'h0000_0000);
		rd(`IDX_PRIM_STATUS);
		chk("summary ro", rv, 32'h0000_2000);
		wr(`IDX_PRIM_MASK, 32'h0000_2000);
		rd(`IDX_PRIM_STATUS);
		chk("summary kept", rv, 32'h0000_2000);
		chk("primary mask", irq_n, 1'b1);
		@(posedge aclk);
		gpio_pin <= 16'h0000;
		repeat (8) @(posedge aclk);
		rd(`IDX_GPIO_STATUS);
		chk("pin fall", rv, 32'h0000_000E);
		wr(`IDX_GPIO_STATUS, 32'h0000_FFFF);
		rd(`IDX_PRIM_STATUS);
		chk("summary clear", rv, 32'h0000_0000);
		chk("requests", irq_seen, 8'h07);
		$display("test pins done");
		wrap_up();
	end
endmodule
